// ### core/cers_pkg.sv
// constants for the per-channel dual event register sets
// assumes one engine clock shared by the microengine and channel logic
package cers_pkg;
   localparam int          CERS_VALUE_W      = 24;
   localparam int          CERS_TBS_W        = 3;
   localparam int          CERS_SRC_W        = 4;
   // field positions inside a time base selection
   localparam int          CERS_TBS_MATCH    = 0;
   localparam int          CERS_TBS_CAPTURE  = 1;
   localparam int          CERS_TBS_EQUAL    = 2;
   localparam logic [2:0]  CERS_TBS_RESET    = 3'h0;
   // source operand code that reads back the match registers
   localparam logic [3:0]  CERS_SRC_MATCH_RD = 4'h5;
   // greater-or-equal window is half the time base range
   localparam logic [23:0] CERS_GE_SPAN      = 24'h800000;
   localparam int          CERS_CHANNELS     = 32;
endpackage : cers_pkg

// ### core/cers_event_regs.sv
// dual event register sets for every channel of one engine
// assumes microengine strobes are one-cycle pulses on clk; the
// match and capture event inputs come from same-clock channel logic
//
// Overview of operation
// - two identical event sets per channel
// - 24-bit match value per set
// - 24-bit capture samples selected time base
// - transitions ordered first then second set
// - accesses act on selected channel
// - selection copies captures into transfer registers
// - flags sampled with captures coherently
// - mode bits sampled at slot switch
// - same-value select still refreshes transfers and flags
// - flag and select writes act immediately
// - microcode may clear, never set latches
// - clearing latch clears sampled branch flag
// - match load sets enable; negate immediate
// - match recognition negates its enable
// - match values loaded only via transfer
// - source code 0101 reads back matches
// - captures reachable only through transfer copy
// - match and capture values not reset
// - reset clears latches, enables, selections
// - shared time bases, per-set selection
// - mode bits host written, engine tests
// - mode bits not channel qualified
// - greater-equal window N to N+0x7FFFFF
`timescale 1ns/1ps
module cers_event_regs
   import cers_pkg::*;
#(
   parameter int NUM_CH = CERS_CHANNELS,
   parameter int MODE_W = 2,
   parameter int CH_W   = (NUM_CH > 1) ? $clog2(NUM_CH) : 1
)
(
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   // shared time bases
   input  wire logic [CERS_VALUE_W-1:0] time_base_one,
   input  wire logic [CERS_VALUE_W-1:0] time_base_two,
   // channel selection
   input  wire logic                    slot_switch,
   input  wire logic [CH_W-1:0]         serviced_channel,
   input  wire logic                    channel_select_write,
   input  wire logic [CH_W-1:0]         channel_select_wdata,
   // host function mode bits
   input  wire logic [MODE_W-1:0]       host_mode,
   // microengine writes to the selected channel
   input  wire logic                    match_write_first,
   input  wire logic                    match_write_second,
   input  wire logic [CERS_VALUE_W-1:0] xfer_wdata_first,
   input  wire logic [CERS_VALUE_W-1:0] xfer_wdata_second,
   input  wire logic                    src_select_valid,
   input  wire logic [CERS_SRC_W-1:0]   source_operand_select,
   input  wire logic                    src_second_set,
   input  wire logic                    enable_clear_first,
   input  wire logic                    enable_clear_second,
   input  wire logic                    tbs_write_first,
   input  wire logic                    tbs_write_second,
   input  wire logic [CERS_TBS_W-1:0]   tbs_wdata,
   input  wire logic                    mlatch_clear_first,
   input  wire logic                    mlatch_clear_second,
   input  wire logic                    tlatch_clear_first,
   input  wire logic                    tlatch_clear_second,
   // channel events, one bit per channel
   input  wire logic [NUM_CH-1:0]       transition_event_first,
   input  wire logic [NUM_CH-1:0]       transition_event_second,
   input  wire logic [NUM_CH-1:0]       match_accept_first,
   input  wire logic [NUM_CH-1:0]       match_accept_second,
   // engine side results
   output logic [CH_W-1:0]              channel_select,
   output logic [CERS_VALUE_W-1:0]      transfer_reg_first,
   output logic [CERS_VALUE_W-1:0]      transfer_reg_second,
   output logic [3:0]                   branch_flags,
   output logic [MODE_W-1:0]            mode_sampled,
   // channel side results
   output logic [NUM_CH-1:0]            match_hit_first,
   output logic [NUM_CH-1:0]            match_hit_second,
   output logic [NUM_CH-1:0]            match_enable_first,
   output logic [NUM_CH-1:0]            match_enable_second,
   output logic [NUM_CH-1:0]            match_latch_first,
   output logic [NUM_CH-1:0]            match_latch_second,
   output logic [NUM_CH-1:0]            transition_latch_first,
   output logic [NUM_CH-1:0]            transition_latch_second
);

   // time base picked by one select bit
   function automatic logic [CERS_VALUE_W-1:0] pick_tb
      (input logic sel,
       input logic [CERS_VALUE_W-1:0] one,
       input logic [CERS_VALUE_W-1:0] two);
      pick_tb = sel ? two : one;
   endfunction : pick_tb

   // equal-only or greater-equal compare; wraps modulo 2^24
   function automatic logic cmp_hit
      (input logic equal_only,
       input logic [CERS_VALUE_W-1:0] tb,
       input logic [CERS_VALUE_W-1:0] mv);
      logic [CERS_VALUE_W-1:0] diff;
      diff = tb - mv;
      cmp_hit = equal_only ? (diff == '0) : (diff < CERS_GE_SPAN);
   endfunction : cmp_hit

   // per-channel storage; values are deliberately not reset, so a
   // thread must load a match before arming it and must not trust a
   // capture copy until an event has written it; each channel holds
   // two identical sets, first action and second action
   logic [CERS_VALUE_W-1:0] match_first_mem   [NUM_CH];
   logic [CERS_VALUE_W-1:0] match_second_mem  [NUM_CH];
   logic [CERS_VALUE_W-1:0] capture_first_mem [NUM_CH];
   logic [CERS_VALUE_W-1:0] capture_second_mem[NUM_CH];
   logic [CERS_TBS_W-1:0]   tbs_first_reg     [NUM_CH];
   logic [CERS_TBS_W-1:0]   tbs_second_reg    [NUM_CH];
   logic [MODE_W-1:0]       mode_reg;

   // selection strobes and the channel they address
   wire logic            select_now = slot_switch | channel_select_write;
   wire logic [CH_W-1:0] new_channel_select   = slot_switch ? serviced_channel
                                                  : channel_select_wdata;
   wire logic            match_read = src_select_valid & src_second_set
             & (source_operand_select == CERS_SRC_MATCH_RD);

   // per-channel compare against each set's chosen time base
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : g_cmp
         assign match_hit_first[g] = cmp_hit(
            tbs_first_reg[g][CERS_TBS_EQUAL],
            pick_tb(tbs_first_reg[g][CERS_TBS_MATCH],
                    time_base_one, time_base_two),
            match_first_mem[g]);
         assign match_hit_second[g] = cmp_hit(
            tbs_second_reg[g][CERS_TBS_EQUAL],
            pick_tb(tbs_second_reg[g][CERS_TBS_MATCH],
                    time_base_one, time_base_two),
            match_second_mem[g]);
      end
   endgenerate

   // writes apply to the selected channel only
   logic [NUM_CH-1:0] sel_dec;
   always_comb
   begin
      sel_dec = '0;
      sel_dec[channel_select] = 1'b1;
   end

   // latch, enable and selection state per channel
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : g_ch
         wire logic here = sel_dec[g];
         // recognition only while enabled; the set wins over a clear
         wire logic mrec1 = match_accept_first[g] & match_enable_first[g];
         wire logic mrec2 = match_accept_second[g]
                            & match_enable_second[g];
         // second transition needs the first latched or arriving in the same cycle
         wire logic tr2 = transition_event_second[g]
                          & (transition_latch_first[g]
                             | transition_event_first[g]);

         // next latch values; microcode can only clear, and a hardware
         // event in the same cycle as a clear wins so no event is lost
         wire logic ml1_next = mrec1
            | (match_latch_first[g] & ~(here & mlatch_clear_first));
         wire logic ml2_next = mrec2
            | (match_latch_second[g] & ~(here & mlatch_clear_second));
         wire logic tl1_next = transition_event_first[g]
            | (transition_latch_first[g] & ~(here & tlatch_clear_first));
         wire logic tl2_next = tr2
            | (transition_latch_second[g] & ~(here & tlatch_clear_second));

         // next enables: a load arms, a clear or recognition disarms;
         // the disarm wins so a same-cycle load cannot re-arm the set
         wire logic me1_next =
            (mrec1 | (here & enable_clear_first)) ? 1'b0 :
            (here & match_write_first) ? 1'b1 :
            match_enable_first[g];
         wire logic me2_next =
            (mrec2 | (here & enable_clear_second)) ? 1'b0 :
            (here & match_write_second) ? 1'b1 :
            match_enable_second[g];

         // next time base selections, written straight into the channel
         wire logic [CERS_TBS_W-1:0] timebase_select_first_next =
            (here & tbs_write_first) ? tbs_wdata : tbs_first_reg[g];
         wire logic [CERS_TBS_W-1:0] timebase_select_second_next =
            (here & tbs_write_second) ? tbs_wdata : tbs_second_reg[g];

         // first match recognition latch
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               match_latch_first[g] <= 1'b0;
            else
               match_latch_first[g] <= ml1_next;
         end

         // second match recognition latch
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               match_latch_second[g] <= 1'b0;
            else
               match_latch_second[g] <= ml2_next;
         end

         // first transition latch
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               transition_latch_first[g] <= 1'b0;
            else
               transition_latch_first[g] <= tl1_next;
         end

         // second transition latch; ordering is in tr2
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               transition_latch_second[g] <= 1'b0;
            else
               transition_latch_second[g] <= tl2_next;
         end

         // first match enable
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               match_enable_first[g] <= 1'b0;
            else
               match_enable_first[g] <= me1_next;
         end

         // second match enable
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               match_enable_second[g] <= 1'b0;
            else
               match_enable_second[g] <= me2_next;
         end

         // first time base selection
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               tbs_first_reg[g] <= CERS_TBS_RESET;
            else
               tbs_first_reg[g] <= timebase_select_first_next;
         end

         // second time base selection
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               tbs_second_reg[g] <= CERS_TBS_RESET;
            else
               tbs_second_reg[g] <= timebase_select_second_next;
         end

         // values: matches only via transfer, captures on events
         always_ff @(posedge clk)
         begin
            if (here && match_write_first)
               match_first_mem[g] <= xfer_wdata_first;
            if (here && match_write_second)
               match_second_mem[g] <= xfer_wdata_second;
            if (mrec1 || transition_event_first[g])
               capture_first_mem[g] <= pick_tb(
                  tbs_first_reg[g][CERS_TBS_CAPTURE],
                  time_base_one, time_base_two);
            if (mrec2 || tr2)
               capture_second_mem[g] <= pick_tb(
                  tbs_second_reg[g][CERS_TBS_CAPTURE],
                  time_base_one, time_base_two);
         end
      end
   endgenerate

   // channel select register; slot switch has priority over a write
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         channel_select <= '0;
      else if (select_now)
         channel_select <= new_channel_select;
   end

   // transfer registers: captures on selection, matches on readback
   always_ff @(posedge clk)
   begin
      if (select_now)
      begin
         transfer_reg_first  <= capture_first_mem[new_channel_select];
         transfer_reg_second <= capture_second_mem[new_channel_select];
      end
      else if (match_read)
      begin
         transfer_reg_first  <= match_first_mem[channel_select];
         transfer_reg_second <= match_second_mem[channel_select];
      end
   end

   // branch flags {tdl2,tdl1,mrl2,mrl1}, sampled with the captures;
   // a clear of the live latch drops the sampled copy too
   wire logic [3:0] live_flags = {transition_latch_second[new_channel_select],
                                  transition_latch_first[new_channel_select],
                                  match_latch_second[new_channel_select],
                                  match_latch_first[new_channel_select]};
   wire logic [3:0] flag_clear = {tlatch_clear_second, tlatch_clear_first,
                                  mlatch_clear_second, mlatch_clear_first};
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         branch_flags <= 4'h0;
      else if (select_now)
         branch_flags <= live_flags;
      else
         branch_flags <= branch_flags & ~flag_clear;
   end

   // mode bits: held stable across the thread, not channel qualified
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         mode_reg <= '0;
      else if (slot_switch)
         mode_reg <= host_mode;
   end
   assign mode_sampled = mode_reg;

endmodule : cers_event_regs

// ### sim/cers_event_regs_properties.sv
// assertions on the ports of the event register sets
// assumes one clock and the async active-low reset
`timescale 1ns/1ps
module cers_event_regs_properties
   import cers_pkg::*;
#(
   parameter int NUM_CH = 4,
   parameter int MODE_W = 2,
   parameter int CH_W   = 2
)
(
   // inputs of the top
   input wire logic clk, reset_n, slot_switch, channel_select_write,
   input wire logic match_write_first, enable_clear_first,
   input wire logic mlatch_clear_first,
   input wire logic [CH_W-1:0] serviced_channel, channel_select_wdata,
   input wire logic [MODE_W-1:0] host_mode,
   input wire logic [NUM_CH-1:0] match_accept_first,
   // outputs of the top
   input wire logic [CH_W-1:0] channel_select,
   input wire logic [3:0] branch_flags,
   input wire logic [MODE_W-1:0] mode_sampled,
   input wire logic [NUM_CH-1:0] match_enable_first, match_latch_first,
   input wire logic [NUM_CH-1:0] transition_latch_first,
   input wire logic [NUM_CH-1:0] transition_latch_second
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // selection writes move the target, so skip them in write checks
   logic no_sel;
   assign no_sel = !slot_switch && !channel_select_write;
   AST_SLOT_SELECT:
      assert property (slot_switch |=> channel_select ==
         $past(serviced_channel) && mode_sampled == $past(host_mode))
      else $error("slot switch selection wrong");
   AST_CHANNEL_SELECT_WRITE:
      assert property (channel_select_write && !slot_switch |=>
         channel_select == $past(channel_select_wdata))
      else $error("channel write not taken");
   AST_MODE_HOLD:
      assert property (!slot_switch |=> $stable(mode_sampled))
      else $error("mode bits moved without slot switch");
   AST_LOAD_ENABLE:
      assert property (match_write_first && !enable_clear_first && no_sel
         && !match_accept_first[channel_select] |=>
         match_enable_first[$past(channel_select)])
      else $error("match load left enable low");
   AST_CLEAR_ENABLE:
      assert property (enable_clear_first |=>
         !match_enable_first[$past(channel_select)])
      else $error("enable clear not immediate");
   AST_LATCH_CAUSE:
      assert property (((match_latch_first & ~$past(match_latch_first))
         & ~$past(match_accept_first & match_enable_first)) == '0)
      else $error("match latch set without enabled match");
   AST_FLAG_CLEAR:
      assert property (mlatch_clear_first && no_sel
         && !match_accept_first[channel_select] |=>
         !match_latch_first[$past(channel_select)] && !branch_flags[0])
      else $error("latch or branch flag survived clear");
   AST_TRANS_ORDER:
      assert property (((transition_latch_second
         & ~$past(transition_latch_second)) & ~transition_latch_first) == '0)
      else $error("second transition latched before first");
endmodule : cers_event_regs_properties
bind cers_event_regs cers_event_regs_properties #(.NUM_CH(NUM_CH),
   .MODE_W(MODE_W), .CH_W(CH_W)) cers_event_regs_properties_i (.*);

// ### sim/cers_ucode_model.sv
// microengine model: one-cycle strobes at the selected channel
// assumes strobes are taken on the rising clk edge
`timescale 1ns/1ps
module cers_ucode_model
   import cers_pkg::*;
#(
   parameter int CH_W = 2
)
(
   input wire logic clk,
   // strobes
   output logic slot_switch, channel_select_write, src_select_valid,
   output logic match_write_first, match_write_second,
   output logic enable_clear_first, enable_clear_second,
   output logic tbs_write_first, tbs_write_second,
   output logic mlatch_clear_first, mlatch_clear_second,
   output logic tlatch_clear_first, tlatch_clear_second,
   // data qualifying the strobes
   output logic src_second_set,
   output logic [CH_W-1:0] serviced_channel, channel_select_wdata,
   output logic [CERS_SRC_W-1:0] source_operand_select,
   output logic [CERS_TBS_W-1:0] tbs_wdata,
   output logic [CERS_VALUE_W-1:0] xfer_wdata_first, xfer_wdata_second
);
   logic [12:0] strb;
   // one bit per microoperation, low between requests
   assign {tlatch_clear_second, tlatch_clear_first, mlatch_clear_second,
      mlatch_clear_first, tbs_write_second, tbs_write_first,
      enable_clear_second, enable_clear_first, src_select_valid,
      match_write_second, match_write_first, slot_switch,
      channel_select_write} = strb;
   initial
   begin
      strb = '0;
      {channel_select_wdata, serviced_channel, source_operand_select, tbs_wdata,
         src_second_set, xfer_wdata_first, xfer_wdata_second} = '0;
   end
   // match values reach the channel only by a load strobe
   task automatic op(input logic [12:0] m, input logic [23:0] a, b);
      @(posedge clk);
      strb <= m;
      channel_select_wdata <= a[CH_W-1:0];
      serviced_channel <= a[CH_W-1:0];
      source_operand_select <= a[CERS_SRC_W-1:0];
      tbs_wdata <= a[CERS_TBS_W-1:0];
      src_second_set <= b[0];
      xfer_wdata_first <= a;
      xfer_wdata_second <= b;
      @(posedge clk);
      strb <= '0;
      #1;
   endtask : op
endmodule : cers_ucode_model

// ### sim/channel_event_register_sets_test.sv
// self-checking bench for the channel event register sets
// assumes the microengine model issues every strobe
`timescale 1ns/1ps
module channel_event_register_sets_test
   import cers_pkg::*;
;
   localparam int N = 4;
   localparam logic [12:0] CW = 13'h0001, SS = 13'h0002, MW = 13'h000C;
   localparam logic [12:0] SRC = 13'h0010, EC2 = 13'h0040;
   localparam logic [12:0] TW = 13'h0180, CLR = 13'h1E20;
   logic clk, reset_n, slot_switch, channel_select_write, src_select_valid;
   logic match_write_first, match_write_second, src_second_set;
   logic enable_clear_first, enable_clear_second, tbs_write_first;
   logic tbs_write_second, mlatch_clear_first, mlatch_clear_second;
   logic tlatch_clear_first, tlatch_clear_second;
   logic [1:0] serviced_channel, channel_select_wdata, channel_select, ch;
   logic [1:0] host_mode, mode_sampled, hm;
   logic [3:0] source_operand_select, branch_flags;
   logic [2:0] tbs_wdata, ts;
   logic [23:0] time_base_one, time_base_two, xfer_wdata_first;
   logic [23:0] xfer_wdata_second, transfer_reg_first, transfer_reg_second;
   logic [23:0] t1, t2, a, b, c1, c2;
   logic [N-1:0] transition_event_first, transition_event_second;
   logic [N-1:0] match_accept_first, match_accept_second;
   logic [N-1:0] match_hit_first, match_hit_second, match_enable_first;
   logic [N-1:0] match_enable_second, match_latch_first, match_latch_second;
   logic [N-1:0] transition_latch_first, transition_latch_second;
   integer seed, failures, n_tests, i;
   cers_event_regs #(.NUM_CH(N)) cers_event_regs_i (.*);
   cers_ucode_model #(.CH_W(2)) cers_ucode_model_i (.*);
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [63:0] g, e);
      n_tests++;
      if (g !== e)
      begin
         failures++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // channel events on the selected channel with fresh time bases
   task automatic ev(input logic [3:0] w);
      @(posedge clk);
      t1 = $random(seed);
      t2 = $random(seed);
      time_base_one <= t1;
      time_base_two <= t2;
      transition_event_first <= w[0] ? 4'h1 << ch : 4'h0;
      transition_event_second <= w[1] ? 4'h1 << ch : 4'h0;
      match_accept_first <= w[2] ? 4'h1 << ch : 4'h0;
      match_accept_second <= w[3] ? 4'h1 << ch : 4'h0;
      if (w[0]) c1 = ts[CERS_TBS_CAPTURE] ? t2 : t1;
      if (w[1]) c2 = ts[CERS_TBS_CAPTURE] ? t2 : t1;
      @(posedge clk);
      {transition_event_first, transition_event_second} <= '0;
      {match_accept_first, match_accept_second} <= '0;
      #1;
   endtask : ev
   task automatic finish_test();
      if (failures == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   initial
   begin
      seed = 2;
      failures = 0;
      n_tests = 0;
      {time_base_one, time_base_two, host_mode} = '0;
      {transition_event_first, transition_event_second} = '0;
      {match_accept_first, match_accept_second} = '0;
      reset_n = 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      #1;
      chk("reset", {channel_select, branch_flags, match_enable_first,
         match_enable_second, match_latch_first, match_latch_second,
         transition_latch_first, transition_latch_second}, '0);
      for (i = 0; i < 8; i++)
      begin
         ch = $random(seed);
         hm = $random(seed);
         ts = $random(seed) & 7;
         a = $random(seed);
         b = $random(seed);
         host_mode <= hm;
         cers_ucode_model_i.op(SS, ch, 0);
         host_mode <= ~hm;
         chk("slot", {channel_select, mode_sampled}, {ch, hm});
         cers_ucode_model_i.op(TW, ts, 0);
         cers_ucode_model_i.op(MW, a, b);
         chk("enable", {match_enable_first, match_enable_second},
            {4'h1 << ch, 4'h1 << ch});
         cers_ucode_model_i.op(SRC, CERS_SRC_MATCH_RD, 1);
         chk("readback", {transfer_reg_first, transfer_reg_second},
            {a, b});
         @(posedge clk);
         time_base_one <= a + 24'h7FFFFF;
         time_base_two <= a + CERS_GE_SPAN;
         #1;
         chk("hit", match_hit_first[ch],
            !ts[CERS_TBS_MATCH] && !ts[CERS_TBS_EQUAL]);
         ev(4'h7);
         chk("latched", {match_latch_first[ch], match_enable_first[ch],
            transition_latch_first[ch], transition_latch_second[ch]},
            4'hB);
         cers_ucode_model_i.op(CW, ch, 0);
         chk("refresh", {transfer_reg_first, transfer_reg_second,
            branch_flags}, {c1, c2, 4'hD});
         cers_ucode_model_i.op(CLR, 0, 0);
         chk("cleared", {branch_flags, match_latch_first,
            transition_latch_first, transition_latch_second}, '0);
         cers_ucode_model_i.op(EC2, 0, 0);
         ev(4'h8);
         chk("disabled", {match_enable_second, match_latch_second},
            '0);
         chk("mode", mode_sampled, hm);
      end
      finish_test();
   end
   // cut a hang well past the 155 or so cycles the run needs
   initial
   begin
      repeat (5000) @(posedge clk);
      failures++;
      finish_test();
   end
endmodule : channel_event_register_sets_test
